//--- hfap_pkg.sv
// Constants for the FIFO host access port: locations, field positions, buffer layout
package hfap_pkg;
  localparam logic [7:0] ADR_ASYNC_FIRST_HOLD = 8'h80;
  localparam logic [7:0] ADR_ASYNC_CONT_HOLD = 8'h84;
  localparam logic [7:0] ADR_ASYNC_FIRST_REL = 8'h88;
  localparam logic [7:0] ADR_ASYNC_CONT_REL = 8'h8C;
  localparam logic [7:0] ADR_ISO_FIRST_HOLD = 8'h90;
  localparam logic [7:0] ADR_ISO_CONT_HOLD = 8'h94;
  localparam logic [7:0] ADR_ISO_FIRST_REL = 8'h98;
  localparam logic [7:0] ADR_ISO_CONT_REL = 8'h9C;
  localparam logic [7:0] ADR_RX_DATA = 8'hC0;
  localparam logic [7:0] ADR_TEST_WINDOW = 8'h80;
  localparam logic [7:0] ADR_ASYNC_STAT = 8'h30;
  localparam logic [7:0] ADR_ISO_STAT = 8'h34;
  localparam logic [7:0] ADR_RX_STAT = 8'h3C;
  localparam logic [7:0] ADR_DIAG = 8'h20;

  localparam int DATA_W = 32;
  localparam int WORD_W = 33;
  localparam int FLAG_BIT = 32;
  localparam int RAM_DEPTH = 512;
  localparam int RAM_AW = 9;
  localparam int TXQ_PW = 7;
  localparam int RXQ_PW = 8;
  localparam logic [8:0] TXQ_SIZE = 9'h080;
  localparam logic [8:0] RXQ_SIZE = 9'h100;
  localparam logic [8:0] ASYNC_BASE = 9'h000;
  localparam logic [8:0] ISO_BASE = 9'h080;
  localparam logic [8:0] RX_BASE = 9'h100;
  localparam int RX_FIFO_DEPTH = 8;

  localparam int ST_FULL = 0;
  localparam int ST_AFULL = 1;
  localparam int ST_FOUR_AVAIL = 4;
  localparam int ST_FOUR_THERE = 12;
  localparam int ST_AEMPTY = 14;
  localparam int ST_EMPTY = 15;
  localparam int ST_CD = 16;
  localparam int ST_CLR = 19;
  localparam int ST_SIZE_LSB = 23;

  localparam int DG_REGISTER_ACCESS_ENABLE = 0;
  localparam int DG_TEST = 1;
  localparam int DG_ADRCLR = 2;
  localparam int DG_CTLVAL = 3;
  localparam int DG_CTLERR = 4;

  localparam logic [31:0] STAT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    HFAP_FIRST_HOLD,
    HFAP_CONT_HOLD,
    HFAP_FIRST_REL,
    HFAP_CONT_REL
  } hfap_kind_t;
endpackage

//--- hfap_stream_if.sv
// Valid/ready stream carrier between the port logic and its input FIFO
`timescale 1ns/1ps
`default_nettype none
interface hfap_stream_if #(parameter int W = 33);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

//--- hfap_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hfap_fifo #(
  parameter int W = 33,
  parameter int D = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  hfap_stream_if.snk in_s,
  hfap_stream_if.src out_s
);
  import hfap_pkg::*;
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] cnt;
  } hfap_fifo_st_t;

  hfap_fifo_st_t st_r;
  hfap_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_s.ready = (st_r.cnt != (PW+1)'(D));
  assign out_s.valid = (st_r.cnt != '0);
  assign out_s.data = st_r.mem[st_r.rptr];

  always_comb begin
    st_nxt = st_r;
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    if (push) begin
      st_nxt.mem[st_r.wptr] = in_s.data;
      st_nxt.wptr = (st_r.wptr == PW'(D - 1)) ? '0 : st_r.wptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rptr = (st_r.rptr == PW'(D - 1)) ? '0 : st_r.rptr + 1'b1;
    end
    // Simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

//--- hfap_access_port.sv
// Host access port for the transmit and receive queues in the shared buffer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Async first-hold stores packet start, not released
// - Async continue-hold stores middle quadlet, not released
// - Async first-release stores start, confirms pending data
// - Async continue-release stores quadlet, confirms packet
// - Iso hold locations store but hold back
// - Iso release locations store and confirm
// - Bad start or underflow makes async stuck
// - Async stuck blocks async until cleared
// - Bad start or underflow makes iso stuck
// - Iso stuck blocks iso until cleared
// - Release with empty flag clears it, requests arbitration
// - Receive data read at one location
// - Test mode needs access and test bits
// - Test mode freezes status, writes change buffer
// - Address-clear resets counter, then clears itself
// - Test accesses walk buffer from location zero
// - Buffer is 512 words, top bit start flag
// - Test write stores data and control value
// - Test read returns data, mismatch sets error
// - Error cleared by address-clear or test write
module hfap_access_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [hfap_pkg::DATA_W-1:0] host_wdata,
  output logic [hfap_pkg::DATA_W-1:0] host_rdata,
  output logic host_rdata_valid,
  input wire logic link_tx_pop,
  input wire logic link_tx_sel,
  output logic [hfap_pkg::DATA_W-1:0] link_tx_data,
  output logic link_tx_first,
  output logic link_tx_valid,
  output logic link_async_avail,
  output logic link_iso_avail,
  output logic phy_arb_req_async,
  output logic phy_arb_req_iso,
  output logic async_tx_stuck_irq,
  output logic iso_tx_stuck_irq,
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  input wire logic [hfap_pkg::DATA_W-1:0] link_rx_data,
  input wire logic link_rx_first
);
  import hfap_pkg::*;

  typedef struct packed {
    logic [TXQ_PW-1:0] wptr;
    logic [TXQ_PW-1:0] rptr;
    logic [8:0] cnt;
    logic [8:0] ccnt;
    logic open;
    logic stuck;
    logic empty_flag;
    logic clr;
  } hfap_txq_t;

  typedef struct packed {
    hfap_txq_t [1:0] txq;
    logic [RXQ_PW-1:0] rx_wptr;
    logic [RXQ_PW-1:0] rx_rptr;
    logic [8:0] rx_cnt;
    logic rx_clr;
    logic register_access_enable;
    logic test;
    logic adrclr;
    logic ctlval;
    logic ctlerr;
    logic [RAM_AW-1:0] ram_addr;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [DATA_W-1:0] tx_data;
    logic tx_first;
    logic tx_valid;
    logic [1:0] arb_req;
  } hfap_st_t;

  hfap_st_t st_r;
  hfap_st_t st_nxt;

  // Buffer contents carry no reset; a flop reset on 16896 bits buys nothing
  logic [WORD_W-1:0] ram [RAM_DEPTH];
  logic ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [WORD_W-1:0] ram_wdata;

  hfap_stream_if #(.W(WORD_W)) rx_in ();
  hfap_stream_if #(.W(WORD_W)) rx_out ();

  assign rx_in.valid = link_rx_valid;
  assign rx_in.data = {link_rx_first, link_rx_data};
  assign link_rx_ready = rx_in.ready;

  hfap_fifo #(.W(WORD_W), .D(RX_FIFO_DEPTH)) u_rx_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  function automatic logic [31:0] stat_word(input logic [8:0] cnt, input logic [8:0] size,
                                            input logic clr, input logic cd);
    logic [31:0] w;
    w = STAT_RESET;
    w[ST_FULL] = (cnt == size);
    w[ST_AFULL] = (cnt == size - 9'h001);
    w[ST_FOUR_AVAIL] = ((size - cnt) >= 9'h004);
    w[ST_AEMPTY] = (cnt == 9'h001);
    w[ST_EMPTY] = (cnt == 9'h000);
    w[ST_CLR] = clr;
    w[ST_SIZE_LSB +: 9] = size;
    if (size == RXQ_SIZE) begin
      w[ST_FOUR_AVAIL] = 1'b0;
      w[ST_FOUR_THERE] = (cnt >= 9'h004);
      w[ST_CD] = cd;
    end
    return w;
  endfunction

  logic test_mode;
  logic tx_wr;
  logic tx_q;
  hfap_kind_t tx_kind;
  logic [8:0] qbase [2];
  logic [WORD_W-1:0] rx_head;
  logic [WORD_W-1:0] test_word;
  logic [WORD_W-1:0] pop_word;

  assign qbase[0] = ASYNC_BASE;
  assign qbase[1] = ISO_BASE;
  assign test_mode = st_r.register_access_enable && st_r.test;
  assign rx_head = ram[RX_BASE + {1'b0, st_r.rx_rptr}];
  // An address clear acting in the same cycle as a test read already points it at zero
  assign test_word = ram[st_r.adrclr ? 9'h000 : st_r.ram_addr];
  assign pop_word = ram[qbase[link_tx_sel] + {2'b00, st_r.txq[link_tx_sel].rptr}];

  // Location decode for the transmit write windows
  always_comb begin
    tx_wr = 1'b0;
    tx_q = 1'b0;
    tx_kind = HFAP_FIRST_HOLD;
    unique case (host_addr)
      ADR_ASYNC_FIRST_HOLD: begin
        tx_wr = 1'b1;
        tx_kind = HFAP_FIRST_HOLD;
      end
      ADR_ASYNC_CONT_HOLD: begin
        tx_wr = 1'b1;
        tx_kind = HFAP_CONT_HOLD;
      end
      ADR_ASYNC_FIRST_REL: begin
        tx_wr = 1'b1;
        tx_kind = HFAP_FIRST_REL;
      end
      ADR_ASYNC_CONT_REL: begin
        tx_wr = 1'b1;
        tx_kind = HFAP_CONT_REL;
      end
      ADR_ISO_FIRST_HOLD: begin
        tx_wr = 1'b1;
        tx_q = 1'b1;
        tx_kind = HFAP_FIRST_HOLD;
      end
      ADR_ISO_CONT_HOLD: begin
        tx_wr = 1'b1;
        tx_q = 1'b1;
        tx_kind = HFAP_CONT_HOLD;
      end
      ADR_ISO_FIRST_REL: begin
        tx_wr = 1'b1;
        tx_q = 1'b1;
        tx_kind = HFAP_FIRST_REL;
      end
      ADR_ISO_CONT_REL: begin
        tx_wr = 1'b1;
        tx_q = 1'b1;
        tx_kind = HFAP_CONT_REL;
      end
      default: begin
        tx_wr = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.tx_valid = 1'b0;
    st_nxt.arb_req = 2'b00;
    ram_we = 1'b0;
    ram_waddr = '0;
    ram_wdata = '0;
    rx_out.ready = 1'b0;

    // Address clear takes effect one cycle after it is written
    if (st_r.adrclr) begin
      st_nxt.ram_addr = '0;
      st_nxt.ctlerr = 1'b0;
      st_nxt.adrclr = 1'b0;
    end

    // Link side pops, frozen while the buffer is under test
    if (link_tx_pop && !test_mode) begin
      if (!st_r.txq[link_tx_sel].stuck) begin
        if (st_r.txq[link_tx_sel].ccnt == 9'h000) begin
          st_nxt.txq[link_tx_sel].stuck = 1'b1;
        end else begin
          st_nxt.txq[link_tx_sel].rptr = st_r.txq[link_tx_sel].rptr + 1'b1;
          st_nxt.txq[link_tx_sel].cnt = st_r.txq[link_tx_sel].cnt - 9'h001;
          st_nxt.txq[link_tx_sel].ccnt = st_r.txq[link_tx_sel].ccnt - 9'h001;
          st_nxt.tx_data = pop_word[DATA_W-1:0];
          st_nxt.tx_first = pop_word[FLAG_BIT];
          st_nxt.tx_valid = 1'b1;
          if (st_r.txq[link_tx_sel].ccnt == 9'h001) begin
            st_nxt.txq[link_tx_sel].empty_flag = 1'b1;
          end
        end
      end
    end

    // Host writes
    if (host_wr) begin
      if (host_addr == ADR_DIAG) begin
        st_nxt.register_access_enable = host_wdata[DG_REGISTER_ACCESS_ENABLE];
        st_nxt.test = host_wdata[DG_TEST];
        st_nxt.ctlval = host_wdata[DG_CTLVAL];
        if (host_wdata[DG_ADRCLR]) begin
          st_nxt.adrclr = 1'b1;
        end
      end else if (host_addr == ADR_ASYNC_STAT) begin
        st_nxt.txq[0].clr = host_wdata[ST_CLR];
      end else if (host_addr == ADR_ISO_STAT) begin
        st_nxt.txq[1].clr = host_wdata[ST_CLR];
      end else if (host_addr == ADR_RX_STAT) begin
        st_nxt.rx_clr = host_wdata[ST_CLR];
      end else if (test_mode) begin
        if (host_addr == ADR_TEST_WINDOW) begin
          ram_we = 1'b1;
          ram_waddr = st_nxt.ram_addr;
          ram_wdata = {st_r.ctlval, host_wdata};
          st_nxt.ram_addr = st_nxt.ram_addr + 1'b1;
          st_nxt.ctlerr = 1'b0;
        end
      end else if (tx_wr && !st_r.txq[tx_q].clr && st_nxt.txq[tx_q].cnt != TXQ_SIZE) begin
        // Full queue ignores the write; a stuck queue still accepts data
        ram_we = 1'b1;
        ram_waddr = qbase[tx_q] + {2'b00, st_r.txq[tx_q].wptr};
        ram_wdata = {1'b0, host_wdata};
        st_nxt.txq[tx_q].wptr = st_r.txq[tx_q].wptr + 1'b1;
        st_nxt.txq[tx_q].cnt = st_nxt.txq[tx_q].cnt + 9'h001;
        unique case (tx_kind)
          HFAP_FIRST_HOLD: begin
            ram_wdata[FLAG_BIT] = 1'b1;
            st_nxt.txq[tx_q].open = 1'b1;
          end
          HFAP_CONT_HOLD: begin
            if (!st_r.txq[tx_q].open) begin
              st_nxt.txq[tx_q].stuck = 1'b1;
            end
          end
          HFAP_FIRST_REL: begin
            ram_wdata[FLAG_BIT] = 1'b1;
            st_nxt.txq[tx_q].open = 1'b0;
            st_nxt.txq[tx_q].ccnt = st_nxt.txq[tx_q].cnt;
          end
          HFAP_CONT_REL: begin
            if (!st_r.txq[tx_q].open) begin
              st_nxt.txq[tx_q].stuck = 1'b1;
            end
            st_nxt.txq[tx_q].open = 1'b0;
            st_nxt.txq[tx_q].ccnt = st_nxt.txq[tx_q].cnt;
          end
        endcase
        if (tx_kind == HFAP_FIRST_REL || tx_kind == HFAP_CONT_REL) begin
          if (st_nxt.txq[tx_q].empty_flag) begin
            st_nxt.txq[tx_q].empty_flag = 1'b0;
            st_nxt.arb_req[tx_q] = 1'b1;
          end
        end
      end
    end

    // Host reads; unmapped locations answer zero
    if (host_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = '0;
      if (host_addr == ADR_DIAG) begin
        st_nxt.rdata[DG_REGISTER_ACCESS_ENABLE] = st_r.register_access_enable;
        st_nxt.rdata[DG_TEST] = st_r.test;
        st_nxt.rdata[DG_ADRCLR] = st_r.adrclr;
        st_nxt.rdata[DG_CTLVAL] = st_r.ctlval;
        st_nxt.rdata[DG_CTLERR] = st_r.ctlerr;
      end else if (host_addr == ADR_ASYNC_STAT) begin
        st_nxt.rdata = stat_word(st_r.txq[0].cnt, TXQ_SIZE, st_r.txq[0].clr, 1'b0);
      end else if (host_addr == ADR_ISO_STAT) begin
        st_nxt.rdata = stat_word(st_r.txq[1].cnt, TXQ_SIZE, st_r.txq[1].clr, 1'b0);
      end else if (host_addr == ADR_RX_STAT) begin
        st_nxt.rdata = stat_word(st_r.rx_cnt, RXQ_SIZE, st_r.rx_clr,
                                 (st_r.rx_cnt != 9'h000) && rx_head[FLAG_BIT]);
      end else if (test_mode) begin
        if (host_addr == ADR_TEST_WINDOW && !host_wr) begin
          st_nxt.rdata = test_word[DATA_W-1:0];
          if (test_word[FLAG_BIT] != st_r.ctlval) begin
            st_nxt.ctlerr = 1'b1;
          end
          st_nxt.ram_addr = st_nxt.ram_addr + 1'b1;
        end
      end else if (host_addr == ADR_RX_DATA && !st_r.rx_clr && st_r.rx_cnt != 9'h000) begin
        st_nxt.rdata = rx_head[DATA_W-1:0];
        st_nxt.rx_rptr = st_r.rx_rptr + 1'b1;
        st_nxt.rx_cnt = st_r.rx_cnt - 9'h001;
      end
    end

    // Receive drain shares the single write port and yields to the host
    if (!test_mode && !st_r.rx_clr && !ram_we && st_r.rx_cnt != RXQ_SIZE) begin
      rx_out.ready = 1'b1;
      if (rx_out.valid) begin
        ram_we = 1'b1;
        ram_waddr = RX_BASE + {1'b0, st_r.rx_wptr};
        ram_wdata = rx_out.data;
        st_nxt.rx_wptr = st_r.rx_wptr + 1'b1;
        st_nxt.rx_cnt = st_nxt.rx_cnt + 9'h001;
      end
    end

    // Clear bits hold their queues empty for as long as they stay set outside test mode
    for (int q = 0; q < 2; q++) begin
      if (st_r.txq[q].clr && !test_mode) begin
        st_nxt.txq[q].wptr = '0;
        st_nxt.txq[q].rptr = '0;
        st_nxt.txq[q].cnt = '0;
        st_nxt.txq[q].ccnt = '0;
        st_nxt.txq[q].open = 1'b0;
        st_nxt.txq[q].stuck = 1'b0;
        st_nxt.txq[q].empty_flag = 1'b1;
      end
    end
    if (st_r.rx_clr && !test_mode) begin
      st_nxt.rx_wptr = '0;
      st_nxt.rx_rptr = '0;
      st_nxt.rx_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.txq[0].empty_flag <= 1'b1;
      st_r.txq[1].empty_flag <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Stuck queue offers nothing to the link
  assign link_async_avail = !test_mode && !st_r.txq[0].stuck && st_r.txq[0].ccnt != 9'h000;
  assign link_iso_avail = !test_mode && !st_r.txq[1].stuck && st_r.txq[1].ccnt != 9'h000;
  assign host_rdata = st_r.rdata;
  assign host_rdata_valid = st_r.rvalid;
  assign link_tx_data = st_r.tx_data;
  assign link_tx_first = st_r.tx_first;
  assign link_tx_valid = st_r.tx_valid;
  assign phy_arb_req_async = st_r.arb_req[0];
  assign phy_arb_req_iso = st_r.arb_req[1];
  assign async_tx_stuck_irq = st_r.txq[0].stuck;
  assign iso_tx_stuck_irq = st_r.txq[1].stuck;
endmodule
`default_nettype wire

//--- hfap_access_port_assertions.sv
// Concurrent checks on the pins of the host access port
`timescale 1ns/1ps
`default_nettype none
module hfap_access_port_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_rdata_valid,
  input wire logic link_tx_pop,
  input wire logic link_tx_sel,
  input wire logic link_tx_valid,
  input wire logic link_async_avail,
  input wire logic link_iso_avail,
  input wire logic link_rx_ready,
  input wire logic phy_arb_req_async,
  input wire logic phy_arb_req_iso,
  input wire logic async_tx_stuck_irq,
  input wire logic iso_tx_stuck_irq
);
  import hfap_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic rel_a;
  logic rel_i;
  assign rel_a = host_wr && (host_addr == ADR_ASYNC_FIRST_REL || host_addr == ADR_ASYNC_CONT_REL);
  assign rel_i = host_wr && (host_addr == ADR_ISO_FIRST_REL || host_addr == ADR_ISO_CONT_REL);
  chk_read_answered: assert property (host_rd |=> host_rdata_valid)
    else $error("read strobe got no answer");
  chk_answer_cause: assert property (host_rdata_valid |-> $past(host_rd))
    else $error("read answer without a read");
  chk_pop_served: assert property (link_tx_pop && !link_tx_sel && link_async_avail |=> link_tx_valid)
    else $error("pop of confirmed async data not served");
  chk_pop_cause: assert property (link_tx_valid |-> $past(link_tx_pop))
    else $error("transmit data without a pop");
  chk_async_blocked: assert property (async_tx_stuck_irq |-> !link_async_avail)
    else $error("async data offered while stuck");
  chk_iso_blocked: assert property (iso_tx_stuck_irq |-> !link_iso_avail)
    else $error("iso data offered while stuck");
  chk_arb_async_src: assert property (phy_arb_req_async |-> $past(rel_a))
    else $error("async arbitration without a release write");
  chk_arb_iso_src: assert property (phy_arb_req_iso |-> $past(rel_i))
    else $error("iso arbitration without a release write");
  chk_hold_async: assert property (host_wr && host_addr inside {8'h80, 8'h84}
    && !link_async_avail |=> !link_async_avail)
    else $error("async hold write released data");
  chk_hold_iso: assert property (host_wr && host_addr inside {8'h90, 8'h94}
    && !link_iso_avail |=> !link_iso_avail)
    else $error("iso hold write released data");
  // The clear bit acts one cycle after its write, so that cycle is excused too
  chk_stuck_kept: assert property (async_tx_stuck_irq
    && !(host_wr && host_addr == ADR_ASYNC_STAT)
    && !$past(host_wr && host_addr == ADR_ASYNC_STAT)
    |=> async_tx_stuck_irq)
    else $error("async stuck left without a clear");
  cov_arb: cover property (phy_arb_req_async);
  cov_iso_stuck: cover property ($rose(iso_tx_stuck_irq));
  cov_pop: cover property (link_tx_valid);
  cov_rx_full: cover property (!link_rx_ready);
endmodule
bind hfap_access_port hfap_access_port_chk i_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_rdata_valid(host_rdata_valid), .link_tx_pop(link_tx_pop),
  .link_tx_sel(link_tx_sel), .link_tx_valid(link_tx_valid), .link_async_avail(link_async_avail),
  .link_iso_avail(link_iso_avail), .link_rx_ready(link_rx_ready),
  .phy_arb_req_async(phy_arb_req_async), .phy_arb_req_iso(phy_arb_req_iso),
  .async_tx_stuck_irq(async_tx_stuck_irq), .iso_tx_stuck_irq(iso_tx_stuck_irq)
);
`default_nettype wire

//--- hfap_host_model.sv
// Host processor model issuing single-cycle reads and writes
`timescale 1ns/1ps
`default_nettype none
module hfap_host_model (
  input wire logic clk_sys,
  output var logic [7:0] host_addr,
  output var logic host_wr,
  output var logic host_rd,
  output var logic [hfap_pkg::DATA_W-1:0] host_wdata,
  input wire logic [hfap_pkg::DATA_W-1:0] host_rdata,
  input wire logic host_rdata_valid
);
  import hfap_pkg::*;
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h0000_0000;
  end
  // Data is inverted after the strobe so a stale bus value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk_sys);
    host_wr <= 1'b0;
    host_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic v, output logic [31:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    #1;
    v = host_rdata_valid;
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

//--- test_fifo_host_access_port.sv
// Self-checking bench for the host access port
`timescale 1ns/1ps
`default_nettype none
module test_fifo_host_access_port;
  import hfap_pkg::*;
  logic clk_sys, arst_n, host_wr, host_rd, host_rdata_valid, link_tx_pop, link_tx_sel;
  logic link_tx_first, link_tx_valid, link_async_avail, link_iso_avail, phy_arb_req_async;
  logic phy_arb_req_iso, async_tx_stuck_irq, iso_tx_stuck_irq, link_rx_valid, link_rx_ready;
  logic link_rx_first, v;
  logic [7:0] host_addr;
  logic [31:0] host_wdata, host_rdata, link_tx_data, link_rx_data, d;
  logic [32:0] pend[2][$];
  logic [32:0] conf[2][$];
  logic [32:0] tm[3];
  logic [31:0] rxq[$];
  int bad_count, n_compared;
  hfap_access_port i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid), .link_tx_pop(link_tx_pop), .link_tx_sel(link_tx_sel),
    .link_tx_data(link_tx_data), .link_tx_first(link_tx_first), .link_tx_valid(link_tx_valid),
    .link_async_avail(link_async_avail), .link_iso_avail(link_iso_avail),
    .phy_arb_req_async(phy_arb_req_async), .phy_arb_req_iso(phy_arb_req_iso),
    .async_tx_stuck_irq(async_tx_stuck_irq), .iso_tx_stuck_irq(iso_tx_stuck_irq),
    .link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready),
    .link_rx_data(link_rx_data), .link_rx_first(link_rx_first));
  hfap_host_model i_host (.clk_sys(clk_sys), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Transmit write plus reference queues: bit 2 of the location marks continue, bit 3 release
  task automatic tw(input logic [7:0] a, input logic [31:0] x);
    int q;
    q = a[4];
    i_host.wr(a, x);
    pend[q].push_back({~a[2], x});
    while (a[3] && pend[q].size() > 0) begin
      conf[q].push_back(pend[q].pop_front());
    end
  endtask
  task automatic clr(input int q);
    i_host.wr(q ? ADR_ISO_STAT : ADR_ASYNC_STAT, 32'h0008_0000);
    i_host.wr(q ? ADR_ISO_STAT : ADR_ASYNC_STAT, 32'h0000_0000);
    pend[q].delete();
    conf[q].delete();
  endtask
  task automatic pop(input int s, input logic ok);
    logic [32:0] e;
    e = ok ? conf[s].pop_front() : 33'h0_0000_0000;
    @(posedge clk_sys);
    link_tx_pop <= 1'b1;
    link_tx_sel <= s[0];
    @(posedge clk_sys);
    link_tx_pop <= 1'b0;
    #1;
    if (ok) begin
      chk({link_tx_valid, link_tx_first, link_tx_data}, {1'b1, e});
    end else begin
      chk(link_tx_valid, 1'b0);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    i_host.rd(a, v, d);
    chk({v, d}, {1'b1, x});
  endtask
  task automatic push(input logic [31:0] x);
    int n;
    n = 0;
    @(posedge clk_sys);
    link_rx_valid <= 1'b1;
    link_rx_data <= x;
    #1;
    while (link_rx_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 50) begin
      bad_count++;
      final_report();
    end
    rxq.push_back(x);
    @(posedge clk_sys);
    link_rx_valid <= 1'b0;
    link_rx_data <= ~x;
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    link_tx_pop = 1'b0;
    link_tx_sel = 1'b0;
    link_rx_valid = 1'b0;
    link_rx_first = 1'b0;
    link_rx_data = 32'h0000_0000;
    bad_count = 0;
    n_compared = 0;
    void'($urandom(21833));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    tw(ADR_ASYNC_FIRST_HOLD, $urandom());
    tw(ADR_ASYNC_CONT_HOLD, $urandom());
    chk(link_async_avail, 1'b0);
    tw(ADR_ASYNC_CONT_REL, $urandom());
    chk({phy_arb_req_async, link_async_avail}, 2'h3);
    tw(ADR_ASYNC_FIRST_REL, $urandom());
    chk(phy_arb_req_async, 1'b0);
    repeat (4) pop(0, 1'b1);
    tw(ADR_ISO_FIRST_HOLD, $urandom());
    tw(ADR_ISO_CONT_HOLD, $urandom());
    chk(link_iso_avail, 1'b0);
    tw(ADR_ISO_CONT_REL, $urandom());
    chk({phy_arb_req_iso, link_iso_avail}, 2'h3);
    tw(ADR_ISO_FIRST_REL, $urandom());
    repeat (4) pop(1, 1'b1);
    tw(ADR_ASYNC_CONT_REL, $urandom());
    tw(ADR_ISO_FIRST_REL, $urandom());
    pop(1, 1'b1);
    chk(async_tx_stuck_irq, 1'b1);
    pop(0, 1'b0);
    clr(0);
    chk(async_tx_stuck_irq, 1'b0);
    tw(ADR_ASYNC_FIRST_REL, $urandom());
    pop(0, 1'b1);
    pop(1, 1'b0);
    tw(ADR_ASYNC_FIRST_REL, $urandom());
    chk(iso_tx_stuck_irq, 1'b1);
    pop(0, 1'b1);
    tw(ADR_ISO_FIRST_REL, $urandom());
    pop(1, 1'b0);
    clr(1);
    chk(iso_tx_stuck_irq, 1'b0);
    repeat (3) push($urandom());
    repeat (3) @(posedge clk_sys);
    repeat (3) rd(ADR_RX_DATA, rxq.pop_front());
    rd(ADR_RX_DATA, 32'h0000_0000);
    i_host.wr(8'hA0, $urandom());
    rd(8'hA0, 32'h0000_0000);
    rd(8'hC4, 32'h0000_0000);
    chk({link_async_avail, link_iso_avail}, 2'h0);
    i_host.wr(ADR_DIAG, 32'h0000_0007);
    for (int i = 0; i < 3; i++) begin
      tm[i][31:0] = $urandom();
      tm[i][32] = i[0];
      i_host.wr(ADR_DIAG, {28'h000_0000, tm[i][32], 3'h3});
      i_host.wr(ADR_TEST_WINDOW, tm[i][31:0]);
    end
    i_host.wr(ADR_DIAG, 32'h0000_0007);
    for (int i = 0; i < 3; i++) begin
      i_host.wr(ADR_DIAG, {28'h000_0000, tm[i][32], 3'h3});
      rd(ADR_TEST_WINDOW, tm[i][31:0]);
    end
    rd(ADR_DIAG, 32'h0000_0003);
    i_host.wr(ADR_DIAG, 32'h0000_000F);
    rd(ADR_TEST_WINDOW, tm[0][31:0]);
    rd(ADR_DIAG, 32'h0000_001B);
    i_host.wr(ADR_TEST_WINDOW, $urandom());
    rd(ADR_ASYNC_STAT, 32'h4000_8010);
    rd(ADR_DIAG, 32'h0000_000B);
    rd(ADR_TEST_WINDOW, tm[2][31:0]);
    i_host.wr(ADR_DIAG, 32'h0000_000F);
    rd(ADR_DIAG, 32'h0000_000B);
    // Drain into the buffer stalls in test mode, so the input FIFO must fill up
    repeat (8) push($urandom());
    chk(link_rx_ready, 1'b0);
    i_host.wr(ADR_DIAG, 32'h0000_0000);
    chk(link_async_avail, 1'b0);
    repeat (20) @(posedge clk_sys);
    repeat (8) rd(ADR_RX_DATA, rxq.pop_front());
    final_report();
  end
endmodule
`default_nettype wire
